//--- hdl/pcs_defines.svh
// Register offsets, field positions, reset values and key for power control
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_ADDR_POWER_CONTROL 8'hC5
`define PCS_ADDR_WRITE_KEY 8'hC1
`define PCS_ADDR_INT_PIN_CFG 8'hFF
`define PCS_ADDR_PERIPHERAL_CONFIG_REG_CFG 8'hF4
`define PCS_ADDR_SWITCHOVER_CFG 8'hF5
`define PCS_ADDR_EVENT_FLAGS 8'hF8
`define PCS_ADDR_STORE_1 8'hFB
`define PCS_ADDR_STORE_2 8'hFC
`define PCS_ADDR_STORE_3 8'hFD
`define PCS_ADDR_STORE_4 8'hFE
`define PCS_WRITE_KEY 8'hA7
`define PCS_POWER_CONTROL_RESET 8'h82
`define PCS_BIT_METER_OFF 6
`define PCS_BIT_CORE_OFF 4
`define PCS_BIT_SUPPLY_SOURCE 6
`define PCS_BIT_SWITCHOVER_EVENT 1
`define PCS_BIT_SUPPLY_RESTORED 7
`define PCS_BIT_SO_DISABLE 1
`define PCS_REF_CLOCK_KHZ 4096
`endif

//--- hdl/pcs_pkg.sv
// Types for the power control and battery switchover block
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_FULL_POWER,
    PCS_BATTERY,
    PCS_SLEEP
  } pcs_mode_t;
endpackage

//--- hdl/pcs_power_switchover.sv
// Power control register, key protection and battery switchover controller
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_power_switchover (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic supply_lost_i,
  // Special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Supply monitors and pin
  input wire logic main_low_i,
  input wire logic dcin_low_i,
  input wire logic battery_control_pin_i,
  // Power controls
  output logic on_main_supply_o,
  output logic metering_enable_o,
  output logic core_stop_o,
  output logic [2:0] core_clock_divide_o,
  output logic core_clk_en_o,
  output pcs_pkg::pcs_mode_t power_mode_o
);

  logic [7:0] power_control_reg, power_control_next;
  logic key_ok_reg, key_ok_next;
  logic [1:0] switchover_select_reg, switchover_select_next;
  logic [2:0] external_int_pin_select_reg, external_int_pin_select_next;
  logic [7:0] store_reg [4];
  logic [7:0] store_next [4];
  logic on_main_reg, on_main_next;
  logic event_flag_reg, event_flag_next;
  logic restored_flag_reg, restored_flag_next;
  logic sleep_reg, sleep_next;
  logic [6:0] div_cnt_reg, div_cnt_next;
  logic [2:0] sync1_reg, sync2_reg;
  logic pin_prev_reg;
  logic main_low_s, dcin_low_s, pin_s;
  logic so_enabled, dcin_en, pin_en, pin_fall, go_backup, go_main;
  logic [6:0] div_mask;
  logic [7:0] rdata_next;

  // Two-stage synchronisers; only stage two is consumed
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      pin_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {battery_control_pin_i, dcin_low_i, main_low_i};
      sync2_reg <= sync1_reg;
      pin_prev_reg <= sync2_reg[2];
    end
  end

  assign main_low_s = sync2_reg[0];
  assign dcin_low_s = sync2_reg[1];
  assign pin_s = sync2_reg[2];

  assign so_enabled = !switchover_select_reg[`PCS_BIT_SO_DISABLE];
  assign dcin_en = (switchover_select_reg == 2'h1);
  assign pin_en = (external_int_pin_select_reg[1:0] == 2'h1);
  assign pin_fall = pin_prev_reg && !pin_s;

  always_comb begin
    go_backup = 1'b0;
    if (so_enabled) begin
      go_backup = main_low_s;
      if (dcin_en && dcin_low_s) begin
        go_backup = 1'b1;
      end
      if (pin_en && pin_fall) begin
        go_backup = 1'b1;
      end
    end
    // All enabled return conditions must hold together
    go_main = !main_low_s;
    if (dcin_en && dcin_low_s) begin
      go_main = 1'b0;
    end
    if (pin_en && !pin_s) begin
      go_main = 1'b0;
    end
    if (!so_enabled) begin
      go_main = 1'b1;
    end
  end

  wire wr_key = sfr_wr_i && (sfr_addr_i == `PCS_ADDR_WRITE_KEY);
  wire wr_pc = sfr_wr_i && (sfr_addr_i == `PCS_ADDR_POWER_CONTROL);
  wire wr_flags = sfr_wr_i && (sfr_addr_i == `PCS_ADDR_EVENT_FLAGS);

  always_comb begin
    power_control_next = power_control_reg;
    key_ok_next = key_ok_reg;
    switchover_select_next = switchover_select_reg;
    external_int_pin_select_next = external_int_pin_select_reg;
    on_main_next = on_main_reg;
    event_flag_next = event_flag_reg;
    restored_flag_next = restored_flag_reg;
    sleep_next = sleep_reg;
    for (int i = 0; i < 4; i++) begin
      store_next[i] = store_reg[i];
    end
    // Any write other than the key consumes the authorisation
    if (sfr_wr_i) begin
      key_ok_next = wr_key && (sfr_wdata_i == `PCS_WRITE_KEY);
    end
    if (wr_pc && key_ok_reg) begin
      // Reserved bit 7 stays one; bits 5 and 3 stay zero regardless of software
      power_control_next = {1'b1, sfr_wdata_i[6], 1'b0, sfr_wdata_i[4], 1'b0,
                            sfr_wdata_i[2:0]};
    end
    if (sfr_wr_i && sfr_addr_i == `PCS_ADDR_SWITCHOVER_CFG) begin
      switchover_select_next = sfr_wdata_i[1:0];
    end
    if (sfr_wr_i && sfr_addr_i == `PCS_ADDR_INT_PIN_CFG) begin
      external_int_pin_select_next = sfr_wdata_i[2:0];
    end
    for (int i = 0; i < 4; i++) begin
      if (sfr_wr_i && sfr_addr_i == `PCS_ADDR_STORE_1 + 8'(i)) begin
        store_next[i] = sfr_wdata_i;
      end
    end
    // Software clears by writing zero; a same-cycle event wins below
    if (wr_flags && !sfr_wdata_i[`PCS_BIT_SWITCHOVER_EVENT]) begin
      event_flag_next = 1'b0;
    end
    if (wr_flags && !sfr_wdata_i[`PCS_BIT_SUPPLY_RESTORED]) begin
      restored_flag_next = 1'b0;
    end
    if (on_main_reg && go_backup) begin
      on_main_next = 1'b0;
      event_flag_next = 1'b1;
    end else if (!on_main_reg && go_main) begin
      on_main_next = 1'b1;
      restored_flag_next = 1'b1;
      sleep_next = 1'b0;
    end
    // Core shutdown only takes effect in battery mode; a return to main this cycle wins
    if (!on_main_next && power_control_reg[`PCS_BIT_CORE_OFF]) begin
      sleep_next = 1'b1;
    end
  end

  // Retained stores ignore the logic reset: only loss of both supplies clears them
  always_ff @(posedge clk_i) begin
    if (supply_lost_i) begin
      for (int i = 0; i < 4; i++) begin
        store_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        store_reg[i] <= store_next[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      power_control_reg <= `PCS_POWER_CONTROL_RESET;
      key_ok_reg <= 1'b0;
      switchover_select_reg <= 2'h0;
      external_int_pin_select_reg <= 3'h0;
      on_main_reg <= 1'b1;
      event_flag_reg <= 1'b0;
      restored_flag_reg <= 1'b0;
      sleep_reg <= 1'b0;
    end else begin
      power_control_reg <= power_control_next;
      key_ok_reg <= key_ok_next;
      switchover_select_reg <= switchover_select_next;
      external_int_pin_select_reg <= external_int_pin_select_next;
      on_main_reg <= on_main_next;
      event_flag_reg <= event_flag_next;
      restored_flag_reg <= restored_flag_next;
      sleep_reg <= sleep_next;
    end
  end

  // Core clock enable: one pulse every 2^divide cycles of the reference rate
  always_comb begin
    div_mask = 7'((8'h01 << power_control_reg[2:0]) - 8'h01);
    div_cnt_next = ((div_cnt_reg & div_mask) == div_mask) ? 7'h00 : 7'(div_cnt_reg + 7'h01);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div_cnt_reg <= 7'h00;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    case (sfr_addr_i)
      `PCS_ADDR_POWER_CONTROL: rdata_next = power_control_reg;
      `PCS_ADDR_SWITCHOVER_CFG: rdata_next = {6'h00, switchover_select_reg};
      `PCS_ADDR_INT_PIN_CFG: rdata_next = {5'h00, external_int_pin_select_reg};
      `PCS_ADDR_PERIPHERAL_CONFIG_REG_CFG: rdata_next = {1'b0, on_main_reg, 6'h00};
      `PCS_ADDR_EVENT_FLAGS: rdata_next = {restored_flag_reg, 5'h00, event_flag_reg, 1'b0};
      `PCS_ADDR_STORE_1: rdata_next = store_reg[0];
      `PCS_ADDR_STORE_2: rdata_next = store_reg[1];
      `PCS_ADDR_STORE_3: rdata_next = store_reg[2];
      `PCS_ADDR_STORE_4: rdata_next = store_reg[3];
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= rdata_next;
    end
  end

  assign on_main_supply_o = on_main_reg;
  // Metering off by software or whenever on backup
  assign metering_enable_o = on_main_reg && !power_control_reg[`PCS_BIT_METER_OFF];
  assign core_stop_o = sleep_reg;
  assign core_clock_divide_o = power_control_reg[2:0];
  assign core_clk_en_o = !sleep_reg && (div_cnt_reg & div_mask) == div_mask;
  assign power_mode_o = sleep_reg ? pcs_pkg::PCS_SLEEP :
                        (on_main_reg ? pcs_pkg::PCS_FULL_POWER : pcs_pkg::PCS_BATTERY);

endmodule

//--- dv/pcs_supply_model.sv
// Supply comparators and battery control pin driver
`timescale 1ns/1ps
module pcs_supply_model (
  input wire logic clk_i,
  input wire logic main_bad_i,
  input wire logic dcin_bad_i,
  input wire logic pin_hi_i,
  output logic main_low_o,
  output logic dcin_low_o,
  output logic pin_o
);
  initial {main_low_o, dcin_low_o, pin_o} = 3'b001;
  // Settle well clear of the edge so sync flops never race the bench
  always @(posedge clk_i) begin
    #3;
    {main_low_o, dcin_low_o, pin_o} <= {main_bad_i, dcin_bad_i, pin_hi_i};
  end
endmodule

//--- dv/pcs_power_switchover_checker.sv
// Port assertions for the power control and switchover block
`timescale 1ns/1ps
module pcs_power_switchover_checker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic main_low_i,
  input wire logic dcin_low_i,
  input wire logic battery_control_pin_i,
  input wire logic on_main_supply_o,
  input wire logic metering_enable_o,
  input wire logic core_stop_o,
  input wire logic [2:0] core_clock_divide_o,
  input wire logic core_clk_en_o,
  input wire pcs_pkg::pcs_mode_t power_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_cause;
    $past(main_low_i | dcin_low_i | !battery_control_pin_i, 2);
  endsequence
  sequence s_pulse;
    core_clk_en_o && core_clock_divide_o != 3'h0 ##1 $stable(core_clock_divide_o);
  endsequence
  sequence s_asleep;
    core_stop_o ##1 core_stop_o;
  endsequence
  AST_SWITCH_CAUSE: assert property ($fell(on_main_supply_o) |-> s_cause)
    else $error("rail left main without cause");
  AST_RESTORE_MAIN_OK: assert property ($rose(on_main_supply_o) |-> !$past(main_low_i, 2))
    else $error("rail returned while main low");
  AST_DIV_PULSE: assert property (s_pulse |-> !core_clk_en_o)
    else $error("clock enable not a single pulse");
  AST_METER_BACKUP: assert property (metering_enable_o |-> on_main_supply_o)
    else $error("metering on backup rail");
  AST_SLEEP_ON_BATTERY: assert property ($rose(core_stop_o) |-> !on_main_supply_o)
    else $error("sleep entered on main");
  AST_SLEEP_CLK: assert property (s_asleep |-> !core_clk_en_o)
    else $error("core clock runs in sleep");
  AST_SLEEP_MODE: assert property (core_stop_o |-> power_mode_o == pcs_pkg::PCS_SLEEP)
    else $error("mode not sleep");
  AST_FULL_ON_MAIN: assert property (power_mode_o == pcs_pkg::PCS_FULL_POWER |-> on_main_supply_o)
    else $error("full power off main");
endmodule
bind pcs_power_switchover pcs_power_switchover_checker pcs_power_switchover_checker_inst (
  .clk_i, .nrst_i, .main_low_i, .dcin_low_i, .battery_control_pin_i, .on_main_supply_o,
  .metering_enable_o, .core_stop_o, .core_clock_divide_o, .core_clk_en_o, .power_mode_o);

//--- dv/testbench.sv
// Self-checking bench for the power control and switchover block
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, nrst_i = 0, supply_lost_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, rd_q = 0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, d;
  logic main_bad = 0, dcin_bad = 0, pin_hi = 1, main_low_i, dcin_low_i, battery_control_pin_i;
  logic on_main_supply_o, metering_enable_o, core_stop_o, core_clk_en_o;
  logic [2:0] core_clock_divide_o;
  logic [15:0] v;
  logic [31:0] r;
  logic [15:0] exp_q[$];
  pcs_pkg::pcs_mode_t power_mode_o;
  int n_mismatch = 0, total_checks = 0, k = 0;
  always #20 clk_i = ~clk_i;
  pcs_supply_model pcs_supply_model_inst (.clk_i, .main_bad_i(main_bad), .dcin_bad_i(dcin_bad),
    .pin_hi_i(pin_hi), .main_low_o(main_low_i), .dcin_low_o(dcin_low_i),
    .pin_o(battery_control_pin_i));
  pcs_power_switchover pcs_power_switchover_inst (.clk_i, .nrst_i, .supply_lost_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .main_low_i, .dcin_low_i,
    .battery_control_pin_i, .on_main_supply_o, .metering_enable_o, .core_stop_o,
    .core_clock_divide_o, .core_clk_en_o, .power_mode_o);
  task chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Reads leave a masked note; the monitor compares once data lands
  task acc(input logic w, input logic [7:0] a, dt, m = 8'hFF);
    sfr_addr_i = a;
    sfr_wdata_i = dt;
    sfr_wr_i = w;
    sfr_rd_i = !w;
    if (!w) exp_q.push_back({m, dt & m});
    @(posedge clk_i);
    #1 sfr_wr_i = 0;
    sfr_rd_i = 0;
    cyc(1);
  endtask
  task pwr(input logic [7:0] dt);
    acc(1, 8'hC1, 8'hA7);
    acc(1, 8'hC5, dt);
  endtask
  always @(posedge clk_i) begin
    if (rd_q) begin
      v = exp_q.pop_front();
      chk(sfr_rdata_o & v[15:8], v[7:0]);
    end
    rd_q <= sfr_rd_i;
  end
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    results;
  end
  initial begin
    r = $urandom(32'hE6A5);
    cyc(6);
    nrst_i = 1;
    acc(0, 8'hC5, 8'h82);
    chk({5'h00, core_clock_divide_o}, 8'h02);
    acc(0, 8'hF4, 8'h40, 8'h40);
    acc(1, 8'hC5, 8'h40);
    acc(0, 8'hC5, 8'h82);
    for (int i = 0; i < 8; i++) begin
      d = {r[i+8], r[i], 1'b0, r[i+16], r[i+24], i[2:0]};
      pwr(d);
      acc(0, 8'hC5, (d & 8'h57) | 8'h80);
      chk({5'h00, core_clock_divide_o}, {5'h00, i[2:0]});
      chk1(metering_enable_o, !d[6]);
    end
    acc(1, 8'hC5, 8'h01);
    acc(0, 8'hC5, (d & 8'h57) | 8'h80);
    $display("test register key done");
    main_bad = 1;
    cyc(6);
    chk1(on_main_supply_o, 0);
    chk1(metering_enable_o, 0);
    acc(0, 8'hF4, 8'h00, 8'h40);
    acc(0, 8'hF8, 8'h02, 8'h02);
    pwr(8'h11);
    chk1(core_stop_o, 1);
    chk({6'h00, power_mode_o}, {6'h00, pcs_pkg::PCS_SLEEP});
    main_bad = 0;
    cyc(6);
    chk1(on_main_supply_o, 1);
    chk({6'h00, power_mode_o}, {6'h00, pcs_pkg::PCS_FULL_POWER});
    acc(0, 8'hF8, 8'h82, 8'h82);
    acc(1, 8'hF8, 8'h00);
    acc(0, 8'hF8, 8'h00, 8'h82);
    pwr(8'h01);
    // Divide code 1: one enable every second cycle
    k = 0;
    repeat (8) begin
      cyc(1);
      k += core_clk_en_o;
    end
    chk(8'(k), 8'h04);
    $display("test main switchover done");
    dcin_bad = 1;
    cyc(6);
    chk1(on_main_supply_o, 1);
    acc(1, 8'hF5, 8'h01);
    cyc(6);
    chk1(on_main_supply_o, 0);
    cyc(6);
    chk1(on_main_supply_o, 0);
    dcin_bad = 0;
    cyc(6);
    chk1(on_main_supply_o, 1);
    acc(1, 8'hFF, {5'h00, r[30], 2'b01});
    pin_hi = 0;
    cyc(6);
    chk1(on_main_supply_o, 0);
    cyc(6);
    chk1(on_main_supply_o, 0);
    pin_hi = 1;
    cyc(6);
    chk1(on_main_supply_o, 1);
    acc(1, 8'hF5, {6'h00, 1'b1, r[31]});
    main_bad = 1;
    cyc(6);
    chk1(on_main_supply_o, 1);
    main_bad = 0;
    $display("test triggers done");
    acc(1, 8'hFE, r[7:0]);
    nrst_i = 0;
    cyc(2);
    nrst_i = 1;
    acc(0, 8'hFE, r[7:0]);
    supply_lost_i = 1;
    cyc(1);
    supply_lost_i = 0;
    acc(0, 8'hFE, 8'h00);
    cyc(3);
    $display("test stores done");
    results;
  end
endmodule
